/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] OPT = wdt_sleep_pkg::OPTION_CONTROL_IDX;
  localparam logic [15:0] CFG = wdt_sleep_pkg::CONFIGURATION_WORD_IDX;
  localparam logic [15:0] STA = wdt_sleep_pkg::STATUS_IDX;
  localparam logic [15:0] CTL = wdt_sleep_pkg::CONTROL_IDX;
  localparam logic [15:0] WEN = wdt_sleep_pkg::WAKE_ENABLE_IDX;
  typedef struct {logic w; logic [15:0] i; logic [7:0] d, e;} row_t;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic clearWatchdogInstr = 0, sleepInstr = 0, vecSeen = 0, serr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [9:0] irqFlagIn = 0;
  logic [15:0] portOutIn = 16'h1234, portOeIn = 16'h00FF, portOut, portOe;
  logic pready, pslverr, internalRcOscOn, oscDriverOn, sleeping;
  logic watchdogReset, wakePulse, vectorReq, prefetchNext, timerPrescaleTick;
  int failures = 0, check_count = 0;
  row_t rows [5] = '{
    '{0, OPT, 8'h00, 8'hFF},
    '{0, CFG, 8'h00, 8'hFF},
    '{0, STA, 8'h00, 8'h18},
    '{1, OPT, 8'h00, 8'h00},
    '{0, OPT, 8'h00, 8'h00}};

  watchdog_sleep_wake_control #(.INTERNAL_RC_OSC_DIV(4), .WDT_BASE_TICKS(4),
    .PORT_WIDTH(16)) watchdog_sleep_wake_control_inst (.sys_clk(sys_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clearWatchdogInstr(clearWatchdogInstr),
    .sleepInstr(sleepInstr), .irqFlagIn(irqFlagIn), .masterClearN(1'b1),
    .portOutIn(portOutIn), .portOeIn(portOeIn), .portOut(portOut),
    .portOe(portOe), .internalRcOscOn(internalRcOscOn),
    .oscDriverOn(oscDriverOn), .sleeping(sleeping),
    .watchdogReset(watchdogReset), .wakePulse(wakePulse),
    .vectorReq(vectorReq), .prefetchNext(prefetchNext),
    .timerPrescaleTick(timerPrescaleTick));

  always #2.5 sys_clk = ~sys_clk;
  // Vector pulse is one cycle; keep a sticky copy for later checks
  always @(posedge sys_clk)
    if (vectorReq === 1'b1)
      vecSeen <= 1;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {14'h0000, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    // Answer and read data are taken at the rising edge that shows pready
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      $display("[ERR] %0t no pready", $time);
    end
    r = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic instr(input logic s);
    @(posedge sys_clk);
    if (s)
      sleepInstr <= 1;
    else
      clearWatchdogInstr <= 1;
    @(posedge sys_clk);
    sleepInstr <= 0;
    clearWatchdogInstr <= 0;
  endtask

  // Looks for a reset (b=0) or wake (b=1) pulse within lim cycles
  task automatic await(input int b, input int lim, input logic e);
    int n;
    logic hit;
    hit = 0;
    for (n = 0; n < lim && !hit; n++)
    begin
      @(negedge sys_clk);
      hit = (b == 0 ? watchdogReset : wakePulse) === 1'b1;
    end
    chk({31'h0, hit}, {31'h0, e});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    foreach (rows[k])
    begin
      apb(rows[k].w, rows[k].i, rows[k].d);
      if (!rows[k].w)
        chk(r, {24'h000000, rows[k].e});
    end
    chk({31'h0, internalRcOscOn}, 32'h1);
    apb(0, 16'h0050, 8'h00);
    chk({31'h0, serr}, 32'h1);
    repeat (12)
    begin
      instr(0);
      await(0, 8, 0);
    end
    await(0, 60, 1);
    apb(0, STA, 8'h00);
    chk(r, 32'h8);
    apb(1, OPT, 8'h09);
    instr(0);
    await(0, 24, 0);
    await(0, 40, 1);
    apb(1, OPT, 8'h00);
    instr(0);
    instr(1);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, sleeping}, 32'h1);
    apb(0, STA, 8'h00);
    chk(r, 32'h10);
    portOutIn <= 16'hFFFF;
    @(negedge sys_clk);
    chk({16'h0, portOut}, 32'h1234);
    chk({31'h0, oscDriverOn}, 32'h0);
    await(1, 60, 1);
    apb(0, STA, 8'h00);
    chk(r, 32'h0);
    apb(1, OPT, 8'h0F);
    apb(1, WEN, 8'h01);
    apb(1, CTL, 8'h04);
    instr(1);
    repeat (3) @(posedge sys_clk);
    vecSeen <= 0;
    irqFlagIn <= 10'h001;
    await(1, 20, 1);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, vecSeen}, 32'h1);
    instr(0);
    instr(1);
    repeat (3) @(negedge sys_clk);
    chk({31'h0, sleeping}, 32'h0);
    apb(0, STA, 8'h00);
    chk(r, 32'h18);
    irqFlagIn <= 10'h000;
    apb(1, CTL, 8'h00);
    apb(1, WEN, 8'h02);
    instr(1);
    vecSeen <= 0;
    irqFlagIn <= 10'h001;
    await(1, 12, 0);
    irqFlagIn <= 10'h002;
    await(1, 20, 1);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, vecSeen}, 32'h0);
    irqFlagIn <= 10'h000;
    apb(1, OPT, 8'h00);
    apb(1, CFG, 8'hFB);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, internalRcOscOn}, 32'h0);
    await(0, 100, 0);
    tally_and_finish();
  end
endmodule // tb

/* File: watchdog_sleep_wake_control.sv */
// The APB register port was decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Watchdog counts internal RC ticks; enabling it runs the RC oscillator.
// - Unscaled watchdog times out after the nominal 16 ms base period.
// - Time-out while running issues a watchdog-type device reset.
// - Time-out while asleep wakes the device instead of resetting it.
// - Any watchdog time-out clears the active-low timeout status bit.
// - Cleared watchdog enable configuration bit disables the watchdog.
// - One prescaler shared by timer and watchdog, chosen by assign bit.
// - Clear-watchdog and power-down clear counter and assigned postscaler.
// - Clear-watchdog zeroes prescaler count only while it is assigned to the watchdog, and keeps its assignment.
// - Power-down clears watchdog, clears powerdown bit, sets timeout bit.
// - Ports hold their pre-sleep drive state during power-down.
// - Master-clear resets; watchdog or enabled interrupt only resumes.
// - Powerdown status bit set at power-up, cleared by real power-down.
// - Only the listed asynchronous peripheral interrupts may wake; SLEEP_CAPABLE lists all 10 sources, so any enabled source wakes.
// - Next instruction is prefetched while power-down executes.
// - Wake needs the source enable set, regardless of global enable.
// - After wake run next instruction, then vector if global enable set.
// - Pending enabled interrupt makes power-down a no-operation.
// - Interrupt during power-down: complete it fully, then wake at once.
module watchdog_sleep_wake_control #(
  parameter int INTERNAL_RC_OSC_DIV = wdt_sleep_pkg::INTERNAL_RC_OSC_DIV,
  parameter int WDT_BASE_TICKS = wdt_sleep_pkg::WDT_BASE_TICKS,
  parameter int PORT_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clearWatchdogInstr,
  input wire logic sleepInstr,
  input wire logic [wdt_sleep_pkg::NUM_WAKE_SRC-1:0] irqFlagIn,
  input wire logic masterClearN,
  input wire logic [PORT_WIDTH-1:0] portOutIn,
  input wire logic [PORT_WIDTH-1:0] portOeIn,
  output logic [PORT_WIDTH-1:0] portOut,
  output logic [PORT_WIDTH-1:0] portOe,
  output logic internalRcOscOn,
  output logic oscDriverOn,
  output logic sleeping,
  output logic watchdogReset,
  output logic wakePulse,
  output logic vectorReq,
  output logic prefetchNext,
  output logic timerPrescaleTick
);

  // Sources that keep a clock in power-down; the rest cannot wake
  localparam logic [wdt_sleep_pkg::NUM_WAKE_SRC-1:0] SLEEP_CAPABLE =
    10'h3FF;

  logic [7:0] optionQ;
  logic [7:0] configQ;
  logic globalIrqEnableQ;
  logic [wdt_sleep_pkg::NUM_WAKE_SRC-1:0] wakeEnableQ;
  logic timeoutStatusNQ;
  logic powerdownStatusNQ;
  logic [1:0] mclrSyncQ;
  logic [wdt_sleep_pkg::NUM_WAKE_SRC-1:0] irqSync1Q;
  logic [wdt_sleep_pkg::NUM_WAKE_SRC-1:0] irqSync2Q;
  logic [15:0] rcDivQ;
  logic [15:0] wdtCountQ;
  logic [7:0] postCountQ;
  logic [PORT_WIDTH-1:0] portOutQ;
  logic [PORT_WIDTH-1:0] portOeQ;
  logic apbWrite;
  logic apbRead;
  logic wdtOn;
  logic prescaleToWdt;
  logic rcTick;
  logic baseExpire;
  logic timeout;
  logic wdtClear;
  logic irqPending;
  logic sleepTaken;
  logic wakeIrq;
  logic [7:0] postLimit;
  wdt_sleep_pkg::apb_addr_t reqAddr;
  wdt_sleep_pkg::core_event_t evQ;

  typedef enum logic [1:0] {RUN, ASLEEP, WAKE_STEP} power_state_t;
  power_state_t stateQ;

  assign reqAddr.paddr = paddr[17:0];
  assign reqAddr.paddrOk = (paddr[31:18] == 14'h0000);
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !penable && !pwrite;

  assign wdtOn = configQ[wdt_sleep_pkg::WATCHDOG_ENABLE_CFG_BIT];
  assign prescaleToWdt = optionQ[wdt_sleep_pkg::PRESCALER_ASSIGN_BIT];
  assign postLimit = 8'h01 << optionQ[wdt_sleep_pkg::PRESCALE_RATIO_LSB +: 3];
  assign irqPending = |(irqSync2Q & wakeEnableQ & SLEEP_CAPABLE);
  assign sleepTaken = sleepInstr && (stateQ == RUN) && !irqPending;
  assign wdtClear = clearWatchdogInstr || sleepTaken;
  assign rcTick = wdtOn && (rcDivQ == 16'(INTERNAL_RC_OSC_DIV - 1));
  assign baseExpire = rcTick && (wdtCountQ == 16'(WDT_BASE_TICKS - 1));
  assign timeout = baseExpire && !wdtClear &&
    (!prescaleToWdt || (postCountQ == postLimit - 8'h01));
  assign wakeIrq = irqPending && (stateQ == ASLEEP);

  // Pin and interrupt inputs come from other clocks
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mclrSyncQ <= 2'b11;
      irqSync1Q <= '0;
      irqSync2Q <= '0;
    end
    else
    begin
      mclrSyncQ <= {mclrSyncQ[0], masterClearN};
      irqSync1Q <= irqFlagIn;
      irqSync2Q <= irqSync1Q;
    end
  end

  // Register writes; configuration is writable for simulation setup
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      optionQ <= wdt_sleep_pkg::OPTION_CONTROL_RST;
      configQ <= wdt_sleep_pkg::CONFIGURATION_WORD_RST;
      globalIrqEnableQ <= 1'b0;
      wakeEnableQ <= '0;
    end
    else if (apbWrite && reqAddr.paddrOk)
    begin
      unique case (reqAddr.paddr)
        wdt_sleep_pkg::OPTION_CONTROL_ADDR: optionQ <= pwdata[7:0];
        wdt_sleep_pkg::CONFIGURATION_WORD_ADDR: configQ <= pwdata[7:0];
        wdt_sleep_pkg::CONTROL_ADDR:
          globalIrqEnableQ <= pwdata[wdt_sleep_pkg::CTRL_GIE_BIT];
        wdt_sleep_pkg::WAKE_ENABLE_ADDR:
          wakeEnableQ <= pwdata[wdt_sleep_pkg::NUM_WAKE_SRC-1:0];
        default: ;
      endcase
    end
  end

  // RC oscillator divider and watchdog counter
  always_ff @(posedge sys_clk)
  begin
    if (rst || !wdtOn)
      rcDivQ <= 16'h0000;
    else if (rcTick)
      rcDivQ <= 16'h0000;
    else
      rcDivQ <= rcDivQ + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !wdtOn || wdtClear || timeout)
      wdtCountQ <= 16'h0000;
    else if (baseExpire)
      wdtCountQ <= 16'h0000;
    else if (rcTick)
      wdtCountQ <= wdtCountQ + 16'h0001;
  end

  // Shared prescaler: counts timer ticks or watchdog base periods
  always_ff @(posedge sys_clk)
  begin
    if (rst || (wdtClear && prescaleToWdt) || timeout)
      postCountQ <= 8'h00;
    else if (prescaleToWdt && baseExpire)
      postCountQ <= postCountQ + 8'h01;
    else if (!prescaleToWdt && rcTick)
      postCountQ <= (postCountQ == postLimit - 8'h01) ? 8'h00 :
        postCountQ + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      timerPrescaleTick <= 1'b0;
    else
      timerPrescaleTick <= !prescaleToWdt && rcTick &&
        (postCountQ == postLimit - 8'h01);
  end

  // Status bits survive a watchdog reset so software can see the cause
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      timeoutStatusNQ <= 1'b1;
      powerdownStatusNQ <= 1'b1;
    end
    else if (timeout)
      timeoutStatusNQ <= 1'b0;
    else if (sleepTaken)
    begin
      timeoutStatusNQ <= 1'b1;
      powerdownStatusNQ <= 1'b0;
    end
    else if (clearWatchdogInstr)
    begin
      timeoutStatusNQ <= 1'b1;
      powerdownStatusNQ <= 1'b1;
    end
  end

  // Power state machine
  always_ff @(posedge sys_clk)
  begin
    if (rst || !mclrSyncQ[1])
      stateQ <= RUN;
    else
    begin
      unique case (stateQ)
        RUN: if (sleepTaken) stateQ <= ASLEEP;
        ASLEEP: if (wakeIrq || timeout) stateQ <= WAKE_STEP;
        WAKE_STEP: stateQ <= RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      evQ <= '0;
    else
    begin
      evQ.wdtReset <= timeout && (stateQ != ASLEEP);
      evQ.wakePulse <= (stateQ == ASLEEP) && (wakeIrq || timeout);
      evQ.vectorReq <= (stateQ == WAKE_STEP) && globalIrqEnableQ &&
        irqPending;
    end
  end

  // Ports freeze at the power-down instruction
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      portOutQ <= '0;
      portOeQ <= '0;
    end
    else if (stateQ == RUN && !sleepTaken)
    begin
      portOutQ <= portOutIn;
      portOeQ <= portOeIn;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sleeping <= 1'b0;
      oscDriverOn <= 1'b1;
      internalRcOscOn <= 1'b0;
      prefetchNext <= 1'b0;
    end
    else
    begin
      sleeping <= (stateQ == ASLEEP);
      oscDriverOn <= (stateQ != ASLEEP);
      internalRcOscOn <= wdtOn;
      prefetchNext <= sleepInstr && (stateQ == RUN);
    end
  end

  assign watchdogReset = evQ.wdtReset;
  assign wakePulse = evQ.wakePulse;
  assign vectorReq = evQ.vectorReq;
  assign portOut = portOutQ;
  assign portOe = portOeQ;

  // APB read data is registered in setup; access completes in one cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      if (psel && !penable)
      begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        if (!reqAddr.paddrOk)
          pslverr <= 1'b1;
        else if (apbRead || pwrite)
        begin
          unique case (reqAddr.paddr)
            wdt_sleep_pkg::OPTION_CONTROL_ADDR:
              prdata <= {24'h000000, optionQ};
            wdt_sleep_pkg::CONFIGURATION_WORD_ADDR:
              prdata <= {24'h000000, configQ};
            wdt_sleep_pkg::CONTROL_ADDR:
              prdata <= {29'h0, globalIrqEnableQ, 2'b00};
            wdt_sleep_pkg::STATUS_ADDR:
              prdata <= {27'h0, timeoutStatusNQ, powerdownStatusNQ, 3'b000};
            wdt_sleep_pkg::WAKE_ENABLE_ADDR:
              prdata <= {22'h0, wakeEnableQ};
            wdt_sleep_pkg::WAKE_FLAG_ADDR:
              prdata <= {22'h0, irqSync2Q};
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

endmodule // watchdog_sleep_wake_control

/* File: wdt_sleep_checker.sv */
`timescale 1ns/100ps
module wdt_sleep_checker #(
  parameter int PORT_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic sleepInstr,
  input wire logic [PORT_WIDTH-1:0] portOut,
  input wire logic internalRcOscOn,
  input wire logic oscDriverOn,
  input wire logic sleeping,
  input wire logic watchdogReset,
  input wire logic wakePulse,
  input wire logic vectorReq,
  input wire logic prefetchNext
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_sleep_osc_off: assert property (
    sleeping && $past(sleeping) |-> !oscDriverOn)
    else $error("oscillator driver on in sleep");
  a_port_hold: assert property (
    sleeping && $past(sleeping) |-> $stable(portOut))
    else $error("port drive changed in sleep");
  a_asleep_no_reset: assert property (
    sleeping |-> !watchdogReset)
    else $error("watchdog reset while asleep");
  a_wake_exits: assert property (
    wakePulse |-> ##[0:2] !sleeping)
    else $error("still asleep after wake");
  a_prefetch_cause: assert property (
    prefetchNext |-> $past(sleepInstr))
    else $error("prefetch without sleep");
  a_apb_no_wait: assert property (
    psel && !penable |=> pready)
    else $error("no ready after setup");
  a_disabled_quiet: assert property (
    !internalRcOscOn [*4] |-> !watchdogReset)
    else $error("reset with watchdog off");
  a_vector_awake: assert property (
    vectorReq |-> !sleeping)
    else $error("vector while asleep");
  c_reset: cover property (watchdogReset);
  c_wake: cover property (wakePulse);
  c_vector: cover property (vectorReq);
endmodule // wdt_sleep_checker

bind watchdog_sleep_wake_control wdt_sleep_checker #(
  .PORT_WIDTH(PORT_WIDTH)
) checker_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .sleepInstr(sleepInstr),
  .portOut(portOut), .internalRcOscOn(internalRcOscOn),
  .oscDriverOn(oscDriverOn), .sleeping(sleeping),
  .watchdogReset(watchdogReset), .wakePulse(wakePulse),
  .vectorReq(vectorReq), .prefetchNext(prefetchNext));

/* File: wdt_sleep_pkg.sv */
package wdt_sleep_pkg;

  // Register offsets (not all multiples of four: kept as indices)
  localparam logic [15:0] OPTION_CONTROL_IDX = 16'h0081;
  localparam logic [15:0] CONFIGURATION_WORD_IDX = 16'h2007;
  localparam logic [15:0] CONTROL_IDX = 16'h0100;
  localparam logic [15:0] STATUS_IDX = 16'h0101;
  localparam logic [15:0] WAKE_ENABLE_IDX = 16'h0102;
  localparam logic [15:0] WAKE_FLAG_IDX = 16'h0103;
  localparam logic [17:0] OPTION_CONTROL_ADDR = {OPTION_CONTROL_IDX, 2'b00};
  localparam logic [17:0] CONFIGURATION_WORD_ADDR =
    {CONFIGURATION_WORD_IDX, 2'b00};
  localparam logic [17:0] CONTROL_ADDR = {CONTROL_IDX, 2'b00};
  localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [17:0] WAKE_ENABLE_ADDR = {WAKE_ENABLE_IDX, 2'b00};
  localparam logic [17:0] WAKE_FLAG_ADDR = {WAKE_FLAG_IDX, 2'b00};

  // Field positions
  localparam int PRESCALER_ASSIGN_BIT = 3;
  localparam int PRESCALE_RATIO_LSB = 0;
  localparam int WATCHDOG_ENABLE_CFG_BIT = 2;
  localparam int POWERDOWN_STATUS_BIT = 3;
  localparam int TIMEOUT_STATUS_BIT = 4;
  localparam int CTRL_CLEAR_WDT_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_GIE_BIT = 2;
  localparam int NUM_WAKE_SRC = 10;

  // Reset values
  localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
  localparam logic [7:0] CONFIGURATION_WORD_RST = 8'hFF;

  // Timing
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int INTERNAL_RC_OSC_HZ = 31_250;
  localparam int WDT_PERIOD_US = 16_000;
  localparam int INTERNAL_RC_OSC_DIV = SYS_CLK_HZ / INTERNAL_RC_OSC_HZ;
  localparam int WDT_BASE_TICKS = (WDT_PERIOD_US * (INTERNAL_RC_OSC_HZ / 1_000)) / 1_000;

  typedef struct packed {
    logic paddrOk;
    logic [17:0] paddr;
  } apb_addr_t;

  typedef struct packed {
    logic wdtReset;
    logic wakePulse;
    logic vectorReq;
  } core_event_t;

endpackage
